// ### shared/hrs_consts.svh
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH
// register byte offsets
`define HRS_OFF_CTRL       12'h000
`define HRS_OFF_TYPE       12'h004
`define HRS_OFF_HSPEED     12'h008
`define HRS_OFF_CSPEED     12'h00c
`define HRS_OFF_SHIFT      12'h010
`define HRS_OFF_HOMEPOS    12'h014
`define HRS_OFF_POSTDOG    12'h018
`define HRS_OFF_FUNCT3     12'h01c
`define HRS_OFF_ACCEL      12'h020
`define HRS_OFF_STATUS     12'h024
`define HRS_OFF_CURPOS     12'h028
`define HRS_OFF_HOMEMARK   12'h02c
// field positions
`define HRS_CTRL_START     0
`define HRS_CTRL_SERVO_ON  1
`define HRS_CTRL_STOP_HIT  2
`define HRS_TYPE_DIR       4
`define HRS_FT3_DOG_POL    0
// homing type codes
`define HRS_TYPE_COUNT     4'h0
`define HRS_TYPE_DATASET   4'h2
`define HRS_TYPE_STOPPER   4'h3
// reset values
`define HRS_RST_SPEED      16'h0064
`define HRS_RST_CREEP      16'h000a
`define HRS_RST_ACCEL      16'h0064
// timing
`define HRS_DOG_MIN_MS     10
`define HRS_CLK_HZ         10000000
`endif

// ### shared/hrs_pkg.sv
package hrs_pkg;
  typedef enum logic [5:0] {
    HRS_IDLE    = 6'b000001,
    HRS_FAST    = 6'b000010,
    HRS_POSTDOG = 6'b000100,
    HRS_ZSRCH   = 6'b001000,
    HRS_PRESS   = 6'b010000,
    HRS_DONE    = 6'b100000
  } hrs_state_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } hrs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } hrs_apb_rsp_t;

  typedef struct packed {
    logic run;
    logic dir_neg;
    logic [15:0] speed;
    logic [15:0] accel;
  } hrs_motion_t;
endpackage

// ### design/hrs_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs
module hrs_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hrs_sync_st_t;
  hrs_sync_st_t st;
  hrs_sync_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

// ### design/hrs_edge_filt.sv
`timescale 1ns/1ps
`include "hrs_consts.svh"
// dog qualifier: level must hold for MIN_CYC cycles before it counts; the sequencer instance uses 1, not the minimum on-time
module hrs_edge_filt #(
  parameter int MIN_CYC = 100000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lvl,
  output logic rise
);
  typedef struct packed {
    logic [31:0] cnt;
    logic qual;
    logic rise;
  } hrs_filt_st_t;
  hrs_filt_st_t st;
  hrs_filt_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.rise = 1'b0;
    if (!lvl) begin
      next_st.cnt = '0;
      next_st.qual = 1'b0;
    end else if (!st.qual) begin
      if (st.cnt >= 32'(MIN_CYC - 1)) begin
        next_st.qual = 1'b1;
        next_st.rise = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = st.rise;
endmodule

// ### design/hrs_sequencer.sv
`timescale 1ns/1ps
`include "hrs_consts.svh"
module hrs_sequencer #(
  parameter int CLK_HZ = `HRS_CLK_HZ,
  parameter int DOG_MIN_CYC = (`HRS_DOG_MIN_MS * (CLK_HZ / 1000))
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_mode_select_1,
  input wire logic [4:0] table_select,
  input wire logic dog_in,
  input wire logic zphase_in,
  input wire logic [31:0] enc_count,
  output logic motion_run,
  output logic motion_dir_neg,
  output logic [15:0] motion_speed,
  output logic [15:0] motion_accel,
  output logic homing_busy,
  output logic homing_done,
  output logic pos_load,
  output logic [31:0] pos_load_value
);
  logic [6:0] pins_s;
  logic mode_ok;
  logic dog_lvl;
  logic dog_rise;

  hrs_sync #(.W(7)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({op_mode_select_1, table_select, dog_in}),
    .q(pins_s)
  );

  typedef struct packed {
    hrs_pkg::hrs_state_t fsm;
    logic [3:0] type_sel;
    logic dir;
    logic dog_pol;
    logic servo_on;
    logic [15:0] hspeed;
    logic [15:0] cspeed;
    logic [31:0] shift;
    logic [31:0] homepos;
    logic [31:0] postdog;
    logic [15:0] accel;
    logic [31:0] dog_mark;
    logic [31:0] home_mark;
    logic [31:0] dog_cnt;
    logic dog_short;
    logic aborted;
    logic z_d;
    logic start_d;
    logic mode_d;
    hrs_pkg::hrs_motion_t mot;
    logic busy;
    logic done;
    logic ld;
    logic [31:0] ld_val;
    hrs_pkg::hrs_apb_rsp_t rsp;
  } hrs_seq_st_t;

  hrs_seq_st_t st;
  hrs_seq_st_t next_st;

  // signed distance travelled since a marked point, in search direction
  function automatic logic [31:0] hrs_dist(input logic [31:0] now, input logic [31:0] mark,
                                           input logic neg);
    hrs_dist = neg ? (mark - now) : (now - mark);
  endfunction

  assign mode_ok = pins_s[6] && (pins_s[5:1] == 5'h00);
  assign dog_lvl = st.dog_pol ? pins_s[0] : !pins_s[0];

  hrs_edge_filt #(.MIN_CYC(1)) u_dog (
    .pclk(pclk),
    .presetn(presetn),
    .lvl(dog_lvl),
    .rise(dog_rise)
  );

  always_comb begin
    logic start_req;
    logic wr;
    logic rd;
    logic z_rise;
    start_req = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    z_rise = 1'b0;
    next_st = st;
    next_st.ld = 1'b0;
    next_st.rsp.pready = 1'b0;
    next_st.rsp.pslverr = 1'b0;
    next_st.z_d = zphase_in;
    z_rise = zphase_in && !st.z_d;
    wr = psel && penable && pwrite && !st.rsp.pready;
    rd = psel && !penable;

    // one-cycle wait state: answer in access phase
    if (psel && penable && !st.rsp.pready) begin
      next_st.rsp.pready = 1'b1;
    end
    if (rd) begin
      next_st.rsp.prdata = '0;
      if (paddr[11:0] == `HRS_OFF_CTRL) begin
        next_st.rsp.prdata[`HRS_CTRL_SERVO_ON] = st.servo_on;
      end else if (paddr[11:0] == `HRS_OFF_TYPE) begin
        next_st.rsp.prdata = {27'h0, st.dir, st.type_sel};
      end else if (paddr[11:0] == `HRS_OFF_HSPEED) begin
        next_st.rsp.prdata = {16'h0, st.hspeed};
      end else if (paddr[11:0] == `HRS_OFF_CSPEED) begin
        next_st.rsp.prdata = {16'h0, st.cspeed};
      end else if (paddr[11:0] == `HRS_OFF_SHIFT) begin
        next_st.rsp.prdata = st.shift;
      end else if (paddr[11:0] == `HRS_OFF_HOMEPOS) begin
        next_st.rsp.prdata = st.homepos;
      end else if (paddr[11:0] == `HRS_OFF_POSTDOG) begin
        next_st.rsp.prdata = st.postdog;
      end else if (paddr[11:0] == `HRS_OFF_FUNCT3) begin
        next_st.rsp.prdata = {31'h0, st.dog_pol};
      end else if (paddr[11:0] == `HRS_OFF_ACCEL) begin
        next_st.rsp.prdata = {16'h0, st.accel};
      end else if (paddr[11:0] == `HRS_OFF_STATUS) begin
        next_st.rsp.prdata = {22'h0, st.aborted, st.dog_short, mode_ok, st.done, st.busy,
                              5'(st.fsm)};
      end else if (paddr[11:0] == `HRS_OFF_CURPOS) begin
        next_st.rsp.prdata = enc_count;
      end else if (paddr[11:0] == `HRS_OFF_HOMEMARK) begin
        next_st.rsp.prdata = st.home_mark;
      end
    end
    if (psel && penable && !st.rsp.pready && paddr[11:0] > `HRS_OFF_HOMEMARK) begin
      next_st.rsp.pslverr = 1'b1;
    end
    if (wr) begin
      if (paddr[11:0] == `HRS_OFF_CTRL) begin
        start_req = pwdata[`HRS_CTRL_START];
        next_st.servo_on = pwdata[`HRS_CTRL_SERVO_ON];
      end else if (paddr[11:0] == `HRS_OFF_TYPE) begin
        next_st.type_sel = pwdata[3:0];
        next_st.dir = pwdata[`HRS_TYPE_DIR];
      end else if (paddr[11:0] == `HRS_OFF_HSPEED) begin
        next_st.hspeed = pwdata[15:0];
      end else if (paddr[11:0] == `HRS_OFF_CSPEED) begin
        next_st.cspeed = pwdata[15:0];
      end else if (paddr[11:0] == `HRS_OFF_SHIFT) begin
        next_st.shift = pwdata;
      end else if (paddr[11:0] == `HRS_OFF_HOMEPOS) begin
        next_st.homepos = pwdata;
      end else if (paddr[11:0] == `HRS_OFF_POSTDOG) begin
        next_st.postdog = pwdata;
      end else if (paddr[11:0] == `HRS_OFF_FUNCT3) begin
        next_st.dog_pol = pwdata[`HRS_FT3_DOG_POL];
      end else if (paddr[11:0] == `HRS_OFF_ACCEL) begin
        next_st.accel = pwdata[15:0];
      end
    end
    // stopper contact arrives through the control word, not a pin
    next_st.start_d = wr && (paddr[11:0] == `HRS_OFF_CTRL) && pwdata[`HRS_CTRL_STOP_HIT];
    next_st.mode_d = mode_ok;
    // on-time of the synchronised dog level, saturating once the guaranteed minimum is reached
    if (!dog_lvl) begin
      next_st.dog_cnt = '0;
    end else if (st.dog_cnt < 32'(DOG_MIN_CYC)) begin
      next_st.dog_cnt = st.dog_cnt + 32'h0000_0001;
    end
    // a dog that drops early during post-dog travel may hide the z pulse; software must know
    if (st.fsm == hrs_pkg::HRS_POSTDOG && !dog_lvl && st.dog_cnt < 32'(DOG_MIN_CYC)) begin
      next_st.dog_short = 1'b1;
    end
    // a start is the mode input rising, or a software start while in mode
    start_req = mode_ok && (start_req || !st.mode_d);

    case (st.fsm)
      hrs_pkg::HRS_IDLE, hrs_pkg::HRS_DONE: begin
        if (start_req) begin
          next_st.done = 1'b0;
          next_st.dog_short = 1'b0;
          next_st.aborted = 1'b0;
          if (st.type_sel == `HRS_TYPE_COUNT) begin
            next_st.fsm = hrs_pkg::HRS_FAST;
            next_st.busy = 1'b1;
            next_st.mot.run = 1'b1;
            next_st.mot.dir_neg = st.dir;
            next_st.mot.speed = st.hspeed;
            next_st.mot.accel = st.accel;
          end else if (st.type_sel == `HRS_TYPE_DATASET && st.servo_on) begin
            next_st.home_mark = enc_count;
            next_st.ld = 1'b1;
            next_st.ld_val = st.homepos;
            next_st.done = 1'b1;
            next_st.fsm = hrs_pkg::HRS_DONE;
          end else if (st.type_sel == `HRS_TYPE_STOPPER) begin
            next_st.fsm = hrs_pkg::HRS_PRESS;
            next_st.busy = 1'b1;
            next_st.mot.run = 1'b1;
            next_st.mot.dir_neg = st.dir;
            next_st.mot.speed = st.hspeed;
            next_st.mot.accel = st.accel;
          end
        end
      end
      hrs_pkg::HRS_FAST: begin
        if (dog_rise) begin
          next_st.dog_mark = enc_count;
          next_st.mot.speed = st.cspeed;
          next_st.fsm = hrs_pkg::HRS_POSTDOG;
        end
      end
      hrs_pkg::HRS_POSTDOG: begin
        if (hrs_dist(enc_count, st.dog_mark, st.dir) >= st.postdog) begin
          next_st.fsm = hrs_pkg::HRS_ZSRCH;
        end
      end
      hrs_pkg::HRS_ZSRCH: begin
        if (z_rise) begin
          next_st.home_mark = st.dir ? (enc_count - st.shift) : (enc_count + st.shift);
          next_st.mot.run = 1'b0;
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
          next_st.ld = 1'b1;
          next_st.ld_val = st.homepos;
          next_st.fsm = hrs_pkg::HRS_DONE;
        end
      end
      hrs_pkg::HRS_PRESS: begin
        if (st.start_d) begin
          next_st.home_mark = enc_count;
          next_st.mot.run = 1'b0;
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
          next_st.ld = 1'b1;
          next_st.ld_val = st.homepos;
          next_st.fsm = hrs_pkg::HRS_DONE;
        end
      end
      default: begin
        next_st.fsm = hrs_pkg::HRS_IDLE;
      end
    endcase
    // leaving the mode aborts any search in progress
    if (!mode_ok && st.busy) begin
      next_st.fsm = hrs_pkg::HRS_IDLE;
      next_st.aborted = 1'b1;
      next_st.busy = 1'b0;
      next_st.mot.run = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.fsm <= hrs_pkg::HRS_IDLE;
      st.hspeed <= `HRS_RST_SPEED;
      st.cspeed <= `HRS_RST_CREEP;
      st.accel <= `HRS_RST_ACCEL;
      st.mode_d <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rsp.prdata;
  assign pready = st.rsp.pready;
  assign pslverr = st.rsp.pslverr;
  assign motion_run = st.mot.run;
  assign motion_dir_neg = st.mot.dir_neg;
  assign motion_speed = st.mot.speed;
  assign motion_accel = st.mot.accel;
  assign homing_busy = st.busy;
  assign homing_done = st.done;
  assign pos_load = st.ld;
  assign pos_load_value = st.ld_val;
endmodule

// ### sim/hrs_sequencer_checker.sv
`timescale 1ns/1ps
module hrs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic op_mode_select_1,
  input wire logic dog_in,
  input wire logic motion_run,
  input wire logic motion_dir_neg,
  input wire logic [15:0] motion_speed,
  input wire logic homing_busy,
  input wire logic homing_done,
  input wire logic pos_load
);
  // cycles since the dog pin last moved, saturating
  logic [3:0] dog_age;
  logic dog_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_age <= 4'hf;
      dog_q <= 1'b0;
    end else begin
      dog_q <= dog_in;
      dog_age <= (dog_in != dog_q) ? 4'h0 : dog_age + {3'h0, dog_age != 4'hf};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("access not answered");
  property p_err; psel && penable && pready |-> pslverr == (paddr > 32'h2c); endproperty
  a_err: assert property (p_err) else $error("error response wrong");
  property p_pulse; pos_load |=> !pos_load; endproperty
  a_pulse: assert property (p_pulse) else $error("load not a pulse");
  property p_load; pos_load |-> ##[0:2] homing_done; endproperty
  a_load: assert property (p_load) else $error("load without done");
  property p_stop; homing_done |-> !motion_run && !homing_busy; endproperty
  a_stop: assert property (p_stop) else $error("moving after done");
  property p_abort; !op_mode_select_1 [*4] |=> !homing_busy; endproperty
  a_abort: assert property (p_abort) else $error("busy without mode");
  property p_creep;
    motion_run && $past(motion_run) && motion_speed != $past(motion_speed) |-> dog_age < 4'h8;
  endproperty
  a_creep: assert property (p_creep) else $error("speed change without dog");
  property p_dir; motion_run && $past(motion_run) |-> $stable(motion_dir_neg); endproperty
  a_dir: assert property (p_dir) else $error("direction changed in run");
  property p_busy; motion_run |-> homing_busy; endproperty
  a_busy: assert property (p_busy) else $error("run while idle");
  c_load: cover property (pos_load);
  c_err: cover property (pready && pslverr);
  c_abort: cover property ($fell(homing_busy) && !homing_done);
endmodule

bind hrs_sequencer hrs_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pready,
  .pslverr, .op_mode_select_1, .dog_in, .motion_run, .motion_dir_neg, .motion_speed,
  .homing_busy, .homing_done, .pos_load);

// ### sim/hrs_host_model.sv
`timescale 1ns/1ps
// encoder, dog switch and mode pins of the machine; step_div slows the axis
module hrs_host_model #(
  parameter int ZP = 16,
  parameter int DOG_END = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mode_req,
  input wire logic [7:0] step_div,
  input wire logic [31:0] dog_pos,
  input wire logic dog_pol,
  input wire logic motion_run,
  input wire logic motion_dir_neg,
  output logic op_mode_select_1,
  output logic [4:0] table_select,
  output logic dog_in,
  output logic zphase_in,
  output logic [31:0] enc_count
);
  logic [7:0] div;
  logic [31:0] pos;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 8'h0;
      pos <= 32'h0;
    end else if (motion_run) begin
      div <= (div == step_div) ? 8'h0 : div + 8'h1;
      if (div == step_div) begin
        pos <= motion_dir_neg ? pos - 32'h1 : pos + 32'h1;
      end
    end
  end
  assign op_mode_select_1 = mode_req;
  assign table_select = 5'h00;
  // dog stays on past its front end, so the z pulses at 16 and 32 fall inside it
  // trailing edge at 40 sits midway between the z pulses at 32 and 48
  assign dog_in = ($signed(pos) >= $signed(dog_pos) && $signed(pos) < DOG_END) ~^ dog_pol;
  assign zphase_in = motion_run && div == 8'h0 && (pos % ZP) == 0;
  assign enc_count = pos;
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
`include "hrs_consts.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mode_req;
  logic op_mode_select_1, dog_in, zphase_in, motion_run, motion_dir_neg;
  logic homing_busy, homing_done, pos_load;
  logic [31:0] paddr, pwdata, prdata, enc_count, pos_load_value, hs, cs, hp, sh;
  logic [15:0] motion_speed, motion_accel;
  logic [4:0] table_select;
  logic [7:0] step_div;
  logic [32:0] rq[$];
  logic [32:0] lq[$];
  int bad_count, n_checks, i;
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  hrs_sequencer DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .op_mode_select_1, .table_select, .dog_in, .zphase_in, .enc_count,
    .motion_run, .motion_dir_neg, .motion_speed, .motion_accel, .homing_busy, .homing_done,
    .pos_load, .pos_load_value);
  hrs_host_model u_host (.pclk, .presetn, .mode_req, .step_div, .dog_pos(32'd10),
    .dog_pol(1'b1), .motion_run, .motion_dir_neg, .op_mode_select_1, .table_select,
    .dog_in, .zphase_in, .enc_count);
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // read expectations queue up; the monitor compares when the answer lands
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) rq.push_back(e);
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic wt(ref logic s);
    for (int k = 0; k < 3000 && s !== 1'b1; k++) @(negedge pclk);
    cmp({32'h0, s}, 33'h1);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) cmp({pslverr, prdata}, rq.pop_front());
    if (pos_load) cmp({1'b0, pos_load_value}, lq.pop_front());
  end
  initial begin
    #5000000;
    bad_count++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, mode_req, presetn} = '0;
    step_div = 8'd15;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(45));
    hs = 32'h100 + ($urandom & 32'hff);
    cs = 32'h1 + ($urandom & 32'h1f);
    hp = $urandom;
    sh = $urandom & 32'hff;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 32'h08, 0, {17'h0, `HRS_RST_SPEED});
    apb(0, 32'h0c, 0, {17'h0, `HRS_RST_CREEP});
    apb(0, 32'h20, 0, {17'h0, `HRS_RST_ACCEL});
    apb(0, 32'h30, 0, {1'b1, 32'h0});
    apb(1, 32'h08, hs, 0);
    apb(1, 32'h0c, cs, 0);
    apb(1, 32'h10, sh, 0);
    apb(1, 32'h14, hp, 0);
    apb(1, 32'h18, 32'd10, 0);
    apb(1, 32'h1c, 32'h1, 0);
    apb(1, 32'h04, 32'h0, 0);
    $display("test registers done");
    // z at 16 falls inside the post-dog travel and must be passed over
    lq.push_back({1'b0, hp});
    @(posedge pclk) mode_req <= 1'b1;
    wt(motion_run);
    cmp({17'h0, motion_speed}, {1'b0, hs});
    cmp({17'h0, motion_accel}, {17'h0, `HRS_RST_ACCEL});
    for (i = 0; i < 2000 && enc_count !== 32'd17; i++) @(negedge pclk);
    cmp({32'h0, motion_run}, 33'h1);
    cmp({17'h0, motion_speed}, {1'b0, cs});
    wt(homing_done);
    apb(0, 32'h2c, 0, {1'b0, 32'd32 + sh});
    apb(0, 32'h28, 0, {1'b0, 32'd32});
    apb(0, 32'h24, 0, {1'b0, 32'h0000_00c0});
    $display("test count type done");
    @(posedge pclk) mode_req <= 1'b0;
    step_div <= 8'd0;
    apb(1, 32'h04, 32'h10, 0);
    repeat (4) @(posedge pclk);
    mode_req <= 1'b1;
    wt(motion_run);
    cmp({32'h0, motion_dir_neg}, 33'h1);
    @(posedge pclk) mode_req <= 1'b0;
    repeat (6) @(negedge pclk);
    cmp({31'h0, homing_busy, motion_run}, 33'h0);
    apb(0, 32'h24, 0, {1'b0, 32'h0000_0201});
    $display("test abort done");
    apb(1, 32'h04, 32'h2, 0);
    @(posedge pclk) mode_req <= 1'b1;
    repeat (10) @(negedge pclk);
    cmp({32'h0, homing_done}, 33'h0);
    lq.push_back({1'b0, hp});
    apb(1, 32'h00, 32'h2, 0);
    apb(1, 32'h00, 32'h3, 0);
    wt(homing_done);
    apb(0, 32'h2c, 0, {1'b0, enc_count});
    $display("test data set done");
    lq.push_back({1'b0, hp});
    apb(1, 32'h04, 32'h3, 0);
    apb(1, 32'h00, 32'h3, 0);
    wt(motion_run);
    apb(1, 32'h00, 32'h6, 0);
    wt(homing_done);
    repeat (5) @(negedge pclk);
    cmp({1'b0, 32'(lq.size())}, 33'h0);
    $display("test stopper done");
    stop_test();
  end
endmodule
